// File: vdf_defines.svh
`ifndef VDF_DEFINES_SVH
`define VDF_DEFINES_SVH

// Register byte offsets.
`define VDF_OFS_FIELD1_POSITION    8'h00
`define VDF_OFS_FIELD2_POSITION    8'h04
`define VDF_OFS_SPACE_THRESHOLD    8'h08
`define VDF_OFS_CONTROL            8'h0c
`define VDF_OFS_FIELD_BIT_CONTROL  8'h10
`define VDF_OFS_FRAME_SIZE         8'h14
`define VDF_OFS_IRQ_STATUS         8'h18
`define VDF_OFS_IRQ_MASK           8'h1c
`define VDF_OFS_COUNTERS           8'h20

// Position registers: line in the upper half, pixel in the lower half.
`define VDF_POS_LINE_HI            27
`define VDF_POS_LINE_LO            16
`define VDF_POS_PIXEL_HI           11
`define VDF_POS_PIXEL_LO           0
`define VDF_POS_RESET              12'h000

// Threshold register fields.
`define VDF_THR_F2_HI              25
`define VDF_THR_F2_LO              16
`define VDF_THR_DIV_HI             15
`define VDF_THR_DIV_LO             12
`define VDF_THR_F1_HI              9
`define VDF_THR_F1_LO              0
`define VDF_THR_RESET              10'h000
`define VDF_DIV_RESET              4'h1
`define VDF_DIV_ZERO_CODE          4'h0
`define VDF_DIV_ZERO_COUNT         5'h10

// Control register fields.
`define VDF_CTL_ENABLE_BIT         0
`define VDF_CTL_MODE_HI            2
`define VDF_CTL_MODE_LO            1
`define VDF_CTL_MODE_RESET         2'h0

// Field bit control register.
`define VDF_FBIT_BIT               0

// Interrupt status and mask bits.
`define VDF_IRQ_F1_BIT             0
`define VDF_IRQ_F2_BIT             1
`define VDF_IRQ_FRAME_BIT          2
`define VDF_IRQ_W                  3

`endif

// File: vdf_dma_model.sv
`timescale 1ns/1ps
`default_nettype none

module vdf_dma_model (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Request and answer.
   input  wire logic [3:0] latency,
   input  wire logic       request,
   output var  logic       done
);
   logic [3:0] wait_reg;

   // Done pulses one clock after the count loaded from latency on a request reaches one.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_reg <= 4'h0;
         done     <= 1'b0;
      end
      else
      begin
         done <= (wait_reg == 4'h1);
         if (request)
            wait_reg <= latency;
         else if (wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
      end
   end
endmodule // vdf_dma_model

`default_nettype wire

// File: vdf_dma_req.sv
`timescale 1ns/1ps
`default_nettype none

module vdf_dma_req #(
   parameter int SPACE_W = 11
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Channel.
   vdf_req_if.chan   ch
);

   logic pending_reg;
   logic request_reg;
   logic fire;

   // One request per transfer; a new one waits for the previous transfer to finish.
   assign fire = ch.enable && !pending_reg && ({{(16-SPACE_W){1'b0}}, ch.space} >= {6'h00, ch.threshold});

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pending_reg <= 1'b0;
      end
      else if (fire)
      begin
         pending_reg <= 1'b1;
      end
      else if (ch.done || !ch.enable)
      begin
         pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         request_reg <= 1'b0;
      end
      else
      begin
         request_reg <= fire;
      end
   end

   assign ch.request = request_reg;

endmodule // vdf_dma_req

`default_nettype wire

// File: vdf_field_timing.sv
// Notes on behaviour
// - Field 1 start line held in bits 27..16 of field1_position.
// - Field 1 start pixel held in bits 11..0 of field1_position.
// - Field id output goes low at field 1 start line and pixel.
// - Field 2 start line held in bits 27..16 of field2_position.
// - Field 2 start pixel held in bits 11..0 of field2_position.
// - Field id output goes high at field 2 start, in every mode.
// - In BT.656 and Y/C, embedded F bit comes from field bit control register.
// - Reserved bits of both position registers read zero, writes ignored.
// - Luma request allowed when luma FIFO space reaches the active threshold.
// - Chroma requests use half the active threshold, rounded up.
// - Raw mode: single FIFO request when space reaches the active threshold.
// - Field 2 threshold in bits 25..16 applies while field 2 runs.
// - Field 1 threshold in bits 9..0 applies while field 1 runs.
// - Raw mode: pixel counter advances every divisor clocks; divisor resets to one.
// - Divisor code zero means sixteen clocks per pixel count.
// - Threshold register bits 31..26 read zero, writes ignored.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "vdf_defines.svh"

module vdf_field_timing #(
   parameter int SPACE_W = 11
) (
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Register port.
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output var  logic [31:0]          reg_rdata,
   // Display FIFO free space in double words.
   input  wire logic [SPACE_W-1:0]   y_space,
   input  wire logic [SPACE_W-1:0]   cb_space,
   input  wire logic [SPACE_W-1:0]   cr_space,
   // Transfer completion from the DMA engine.
   input  wire logic                 y_dma_done,
   input  wire logic                 cb_dma_done,
   input  wire logic                 cr_dma_done,
   // DMA requests.
   output var  logic                 y_dma_request,
   output var  logic                 cb_dma_request,
   output var  logic                 cr_dma_request,
   // Video outputs.
   output var  logic                 field_id_out,
   output var  logic                 timing_code_f_bit,
   // Interrupt.
   output var  logic                 irq
);
   import vdf_pkg::*;

   // Register state.
   vdf_pos_t              f1_start_line_reg;
   vdf_pos_t              f1_start_pixel_reg;
   vdf_pos_t              f2_start_line_reg;
   vdf_pos_t              f2_start_pixel_reg;
   vdf_thr_t              f1_space_threshold_reg;
   vdf_thr_t              f2_space_threshold_reg;
   logic [3:0]            pixel_clock_divisor_reg;
   logic                  enable_reg;
   logic [1:0]            mode_reg;
   logic                  field_bit_control_reg;
   vdf_pos_t              last_line_reg;
   vdf_pos_t              last_pixel_reg;
   logic [`VDF_IRQ_W-1:0] irq_status_reg;
   logic [`VDF_IRQ_W-1:0] irq_mask_reg;
   logic [31:0]           reg_rdata_reg;
   logic [31:0]           reg_rdata_next;

   // Timing state.
   vdf_pos_t              frame_line_counter;
   vdf_pos_t              frame_pixel_counter;
   logic [4:0]            div_count_reg;
   logic [4:0]            div_value;
   logic                  pixel_advance;
   logic                  field_id_reg;
   logic                  f_bit_reg;
   logic                  irq_reg;
   logic                  f1_hit;
   logic                  f2_hit;
   logic                  frame_end;
   logic                  raw_mode;
   vdf_mode_e             mode;

   // Request channels.
   vdf_thr_t              active_space_threshold;
   vdf_thr_t              chroma_threshold;
   logic [`VDF_IRQ_W-1:0] irq_events;
   logic [`VDF_IRQ_W-1:0] irq_clear;

   vdf_req_if #(.SPACE_W(SPACE_W)) y_ch ();
   vdf_req_if #(.SPACE_W(SPACE_W)) cb_ch ();
   vdf_req_if #(.SPACE_W(SPACE_W)) cr_ch ();

   assign mode     = vdf_mode_e'(mode_reg);
   assign raw_mode = (mode == VDF_MODE_RAW);

   // Register writes.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         f1_start_line_reg  <= `VDF_POS_RESET;
         f1_start_pixel_reg <= `VDF_POS_RESET;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_FIELD1_POSITION)
      begin
         f1_start_line_reg  <= reg_wdata[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO];
         f1_start_pixel_reg <= reg_wdata[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         f2_start_line_reg  <= `VDF_POS_RESET;
         f2_start_pixel_reg <= `VDF_POS_RESET;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_FIELD2_POSITION)
      begin
         f2_start_line_reg  <= reg_wdata[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO];
         f2_start_pixel_reg <= reg_wdata[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         f1_space_threshold_reg  <= `VDF_THR_RESET;
         f2_space_threshold_reg  <= `VDF_THR_RESET;
         pixel_clock_divisor_reg <= `VDF_DIV_RESET;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_SPACE_THRESHOLD)
      begin
         f1_space_threshold_reg  <= reg_wdata[`VDF_THR_F1_HI:`VDF_THR_F1_LO];
         f2_space_threshold_reg  <= reg_wdata[`VDF_THR_F2_HI:`VDF_THR_F2_LO];
         pixel_clock_divisor_reg <= reg_wdata[`VDF_THR_DIV_HI:`VDF_THR_DIV_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_reg <= 1'b0;
         mode_reg   <= `VDF_CTL_MODE_RESET;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_CONTROL)
      begin
         enable_reg <= reg_wdata[`VDF_CTL_ENABLE_BIT];
         mode_reg   <= reg_wdata[`VDF_CTL_MODE_HI:`VDF_CTL_MODE_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         field_bit_control_reg <= 1'b0;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_FIELD_BIT_CONTROL)
      begin
         field_bit_control_reg <= reg_wdata[`VDF_FBIT_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_line_reg  <= `VDF_POS_RESET;
         last_pixel_reg <= `VDF_POS_RESET;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_FRAME_SIZE)
      begin
         last_line_reg  <= reg_wdata[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO];
         last_pixel_reg <= reg_wdata[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_mask_reg <= '0;
      end
      else if (reg_wr && reg_addr == `VDF_OFS_IRQ_MASK)
      begin
         irq_mask_reg <= reg_wdata[`VDF_IRQ_W-1:0];
      end
   end

   // Register reads; an unmapped address reads as zero.
   always_comb
   begin
      reg_rdata_next = 32'h0000_0000;
      unique case (reg_addr)
         `VDF_OFS_FIELD1_POSITION:
         begin
            reg_rdata_next[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO]   = f1_start_line_reg;
            reg_rdata_next[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO] = f1_start_pixel_reg;
         end
         `VDF_OFS_FIELD2_POSITION:
         begin
            reg_rdata_next[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO]   = f2_start_line_reg;
            reg_rdata_next[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO] = f2_start_pixel_reg;
         end
         `VDF_OFS_SPACE_THRESHOLD:
         begin
            reg_rdata_next[`VDF_THR_F2_HI:`VDF_THR_F2_LO]   = f2_space_threshold_reg;
            reg_rdata_next[`VDF_THR_DIV_HI:`VDF_THR_DIV_LO] = pixel_clock_divisor_reg;
            reg_rdata_next[`VDF_THR_F1_HI:`VDF_THR_F1_LO]   = f1_space_threshold_reg;
         end
         `VDF_OFS_CONTROL:
         begin
            reg_rdata_next[`VDF_CTL_ENABLE_BIT]                  = enable_reg;
            reg_rdata_next[`VDF_CTL_MODE_HI:`VDF_CTL_MODE_LO]    = mode_reg;
         end
         `VDF_OFS_FIELD_BIT_CONTROL:
         begin
            reg_rdata_next[`VDF_FBIT_BIT] = field_bit_control_reg;
         end
         `VDF_OFS_FRAME_SIZE:
         begin
            reg_rdata_next[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO]   = last_line_reg;
            reg_rdata_next[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO] = last_pixel_reg;
         end
         `VDF_OFS_IRQ_STATUS:
         begin
            reg_rdata_next[`VDF_IRQ_W-1:0] = irq_status_reg;
         end
         `VDF_OFS_IRQ_MASK:
         begin
            reg_rdata_next[`VDF_IRQ_W-1:0] = irq_mask_reg;
         end
         `VDF_OFS_COUNTERS:
         begin
            reg_rdata_next[`VDF_POS_LINE_HI:`VDF_POS_LINE_LO]   = frame_line_counter;
            reg_rdata_next[`VDF_POS_PIXEL_HI:`VDF_POS_PIXEL_LO] = frame_pixel_counter;
         end
         default:
         begin
            reg_rdata_next = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_reg <= 32'h0000_0000;
      end
      else if (reg_rd)
      begin
         reg_rdata_reg <= reg_rdata_next;
      end
      else
      begin
         reg_rdata_reg <= 32'h0000_0000;
      end
   end

   // Pixel clock divider; outside raw mode every clock is one pixel count.
   assign div_value = (pixel_clock_divisor_reg == `VDF_DIV_ZERO_CODE) ?
                      `VDF_DIV_ZERO_COUNT : {1'b0, pixel_clock_divisor_reg};
   assign pixel_advance = enable_reg && (!raw_mode || (div_count_reg + 5'h01 >= div_value));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_count_reg <= 5'h00;
      end
      else if (!enable_reg || pixel_advance)
      begin
         div_count_reg <= 5'h00;
      end
      else
      begin
         div_count_reg <= div_count_reg + 5'h01;
      end
   end

   // Frame counters.
   assign frame_end = (frame_pixel_counter == last_pixel_reg) && (frame_line_counter == last_line_reg);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_pixel_counter <= 12'h000;
         frame_line_counter  <= 12'h000;
      end
      else if (!enable_reg)
      begin
         frame_pixel_counter <= 12'h000;
         frame_line_counter  <= 12'h000;
      end
      else if (pixel_advance)
      begin
         if (frame_pixel_counter == last_pixel_reg)
         begin
            frame_pixel_counter <= 12'h000;
            frame_line_counter  <= (frame_line_counter == last_line_reg) ? 12'h000 :
                                   frame_line_counter + 12'h001;
         end
         else
         begin
            frame_pixel_counter <= frame_pixel_counter + 12'h001;
         end
      end
   end

   // A position is visited once per frame, and the compare is taken only on the advance.
   assign f1_hit = pixel_advance && (frame_line_counter == f1_start_line_reg) &&
                   (frame_pixel_counter == f1_start_pixel_reg);
   assign f2_hit = pixel_advance && (frame_line_counter == f2_start_line_reg) &&
                   (frame_pixel_counter == f2_start_pixel_reg);

   // Field 2 wins if both positions are programmed alike.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         field_id_reg <= 1'b0;
      end
      else if (f2_hit)
      begin
         field_id_reg <= 1'b1;
      end
      else if (f1_hit)
      begin
         field_id_reg <= 1'b0;
      end
   end

   // The embedded F bit ignores the field output entirely.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         f_bit_reg <= 1'b0;
      end
      else
      begin
         f_bit_reg <= raw_mode ? 1'b0 : field_bit_control_reg;
      end
   end

   // Threshold of the field in progress, and its rounded half for chroma.
   assign active_space_threshold = field_id_reg ? f2_space_threshold_reg :
                                                  f1_space_threshold_reg;
   assign chroma_threshold = {1'b0, active_space_threshold[9:1]} +
                             {9'h000, active_space_threshold[0]};

   assign y_ch.enable     = enable_reg;
   assign y_ch.space      = y_space;
   assign y_ch.threshold  = active_space_threshold;
   assign y_ch.done       = y_dma_done;

   // Raw mode drives one FIFO only, so the chroma channels stay idle.
   assign cb_ch.enable    = enable_reg && !raw_mode;
   assign cb_ch.space     = cb_space;
   assign cb_ch.threshold = chroma_threshold;
   assign cb_ch.done      = cb_dma_done;

   assign cr_ch.enable    = enable_reg && !raw_mode;
   assign cr_ch.space     = cr_space;
   assign cr_ch.threshold = chroma_threshold;
   assign cr_ch.done      = cr_dma_done;

   vdf_dma_req #(.SPACE_W(SPACE_W)) u_y_req (.clk(clk), .rst_n(rst_n), .ch(y_ch.chan));
   vdf_dma_req #(.SPACE_W(SPACE_W)) u_cb_req (.clk(clk), .rst_n(rst_n), .ch(cb_ch.chan));
   vdf_dma_req #(.SPACE_W(SPACE_W)) u_cr_req (.clk(clk), .rst_n(rst_n), .ch(cr_ch.chan));

   // Interrupt status; a new event beats a clear in the same cycle.
   assign irq_events = {enable_reg && pixel_advance && frame_end, f2_hit, f1_hit};
   assign irq_clear  = (reg_wr && reg_addr == `VDF_OFS_IRQ_STATUS) ? reg_wdata[`VDF_IRQ_W-1:0] : '0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_status_reg <= '0;
      end
      else
      begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   assign reg_rdata         = reg_rdata_reg;
   assign y_dma_request     = y_ch.request;
   assign cb_dma_request    = cb_ch.request;
   assign cr_dma_request    = cr_ch.request;
   assign field_id_out      = field_id_reg;
   assign timing_code_f_bit = f_bit_reg;
   assign irq               = irq_reg;

endmodule // vdf_field_timing

`default_nettype wire

// File: vdf_field_timing_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "vdf_defines.svh"

module vdf_field_timing_props #(
   parameter int SPACE_W = 11
) (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst_n,
   // Register port.
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // DMA handshake.
   input wire logic        y_dma_request,
   input wire logic        cb_dma_request,
   input wire logic        cr_dma_request,
   input wire logic        y_dma_done,
   input wire logic        cb_dma_done,
   input wire logic        cr_dma_done,
   // Video output.
   input wire logic        timing_code_f_bit
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   // A request that has not yet seen its done pulse is still pending.
   sequence s_busy(req, done);
      (req && !done) ##1 !done;
   endsequence

   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   property p_pos_res;
      $past(reg_rd) && ($past(reg_addr) == `VDF_OFS_FIELD1_POSITION || $past(reg_addr) == `VDF_OFS_FIELD2_POSITION)
      |-> reg_rdata[31:28] == 4'h0 && reg_rdata[15:12] == 4'h0;
   endproperty
   property p_thr_res;
      $past(reg_rd) && $past(reg_addr) == `VDF_OFS_SPACE_THRESHOLD |-> reg_rdata[31:26] == 6'h0;
   endproperty
   property p_y_pulse;
      y_dma_request |=> !y_dma_request;
   endproperty
   property p_y_busy;
      s_busy(y_dma_request, y_dma_done) |=> !y_dma_request;
   endproperty
   property p_cb_busy;
      s_busy(cb_dma_request, cb_dma_done) |=> !cb_dma_request;
   endproperty
   property p_cr_busy;
      s_busy(cr_dma_request, cr_dma_done) |=> !cr_dma_request;
   endproperty
   // The embedded F bit follows only a register write, never the field output.
   property p_fbit;
      $changed(timing_code_f_bit) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
   endproperty

   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   a_pos_res: assert property (p_pos_res) else $error("position reserved bits set");
   a_thr_res: assert property (p_thr_res) else $error("threshold reserved bits set");
   a_y_pulse: assert property (p_y_pulse) else $error("luma request too long");
   a_y_busy: assert property (p_y_busy) else $error("luma request while pending");
   a_cb_busy: assert property (p_cb_busy) else $error("cb request while pending");
   a_cr_busy: assert property (p_cr_busy) else $error("cr request while pending");
   a_fbit: assert property (p_fbit) else $error("F bit changed without a write");
endmodule // vdf_field_timing_props

bind vdf_field_timing vdf_field_timing_props #(.SPACE_W(SPACE_W)) u_props (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .y_dma_request(y_dma_request), .cb_dma_request(cb_dma_request), .cr_dma_request(cr_dma_request),
   .y_dma_done(y_dma_done), .cb_dma_done(cb_dma_done), .cr_dma_done(cr_dma_done),
   .timing_code_f_bit(timing_code_f_bit)
);

`default_nettype wire

// File: vdf_pkg.sv
package vdf_pkg;

   typedef enum logic [1:0] {
      VDF_MODE_RAW,
      VDF_MODE_BT656,
      VDF_MODE_YC
   } vdf_mode_e;

   typedef logic [11:0] vdf_pos_t;
   typedef logic [9:0]  vdf_thr_t;

endpackage

// File: vdf_req_if.sv
`timescale 1ns/1ps
`default_nettype none

interface vdf_req_if #(parameter int SPACE_W = 11);
   logic                enable;
   logic [SPACE_W-1:0]  space;
   logic [9:0]          threshold;
   logic                done;
   logic                request;

   modport chan (input enable, input space, input threshold, input done, output request);
   modport ctrl (output enable, output space, output threshold, output done, input request);
endinterface

`default_nettype wire

// File: video_display_field_timing_threshold_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "vdf_defines.svh"

module video_display_field_timing_threshold_test;
   import vdf_pkg::*;
   logic        clk, rst_n, reg_wr, reg_rd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [10:0] y_space, c_space;
   logic [3:0]  lat;
   logic        y_req, cb_req, cr_req, y_done, cb_done, cr_done, fid, fbit, irq;
   int          n_errors, checks, n1;

   vdf_field_timing #(.SPACE_W(11)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .y_space(y_space), .cb_space(c_space), .cr_space(c_space),
      .y_dma_done(y_done), .cb_dma_done(cb_done), .cr_dma_done(cr_done), .y_dma_request(y_req),
      .cb_dma_request(cb_req), .cr_dma_request(cr_req), .field_id_out(fid), .timing_code_f_bit(fbit), .irq(irq)
   );
   vdf_dma_model u_y (.clk(clk), .rst_n(rst_n), .latency(lat), .request(y_req), .done(y_done));
   vdf_dma_model u_cb (.clk(clk), .rst_n(rst_n), .latency(lat), .request(cb_req), .done(cb_done));
   vdf_dma_model u_cr (.clk(clk), .rst_n(rst_n), .latency(lat), .request(cr_req), .done(cr_done));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   task automatic wait_fid(input logic v, output int n);
      n = 0;
      while (fid !== v && n < 2000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, fid}, {31'h0, v});
   endtask

   // Frame of 4 lines by 10 pixels: field 2 lasts 17 advances, field 1 lasts 23.
   task automatic fld_case(input vdf_mode_e m, input logic [3:0] div, input int mult, input logic fb);
      int n2;
      wr(`VDF_OFS_SPACE_THRESHOLD, {16'h0, div, 12'h0});
      wr(`VDF_OFS_CONTROL, {29'h0, m, 1'b1});
      wait_fid(1'b0, n1);
      wait_fid(1'b1, n1);
      wait_fid(1'b0, n1);
      wait_fid(1'b1, n2);
      chk(n1, 17 * mult);
      chk(n2, 23 * mult);
      chk({31'h0, fbit}, {31'h0, fb});
      $display("field case done");
   endtask

   // Requests already in flight are let through before counting starts.
   task automatic req_case(input logic [10:0] ys, input logic [10:0] cs, input logic ey, input logic ec);
      int ny, nc;
      ny = 0;
      nc = 0;
      @(posedge clk);
      y_space <= ys;
      c_space <= cs;
      repeat (3) @(posedge clk);
      repeat (16)
      begin
         @(posedge clk);
         #1;
         ny += y_req;
         nc += cb_req + cr_req;
      end
      chk({31'h0, ny != 0}, {31'h0, ey});
      chk({31'h0, nc != 0}, {31'h0, ec});
   endtask

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      stop_test();
   end

   initial
   begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, y_space, c_space} = '0;
      lat = 4'h1;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`VDF_OFS_FIELD1_POSITION, 32'h0);
      rd(`VDF_OFS_FIELD2_POSITION, 32'h0);
      rd(`VDF_OFS_SPACE_THRESHOLD, 32'h0000_1000);
      wr(`VDF_OFS_FIELD1_POSITION, 32'hffff_ffff);
      rd(`VDF_OFS_FIELD1_POSITION, 32'h0fff_0fff);
      wr(`VDF_OFS_FIELD2_POSITION, 32'hffff_ffff);
      rd(`VDF_OFS_FIELD2_POSITION, 32'h0fff_0fff);
      wr(`VDF_OFS_SPACE_THRESHOLD, 32'hffff_ffff);
      rd(`VDF_OFS_SPACE_THRESHOLD, 32'h03ff_f3ff);
      rd(8'h40, 32'h0);
      $display("register test done");
      wr(`VDF_OFS_FRAME_SIZE, 32'h0003_0009);
      wr(`VDF_OFS_FIELD1_POSITION, 32'h0000_0002);
      wr(`VDF_OFS_FIELD2_POSITION, 32'h0002_0005);
      wr(`VDF_OFS_FIELD_BIT_CONTROL, 32'h1);
      fld_case(VDF_MODE_BT656, 4'h1, 1, 1'b1);
      fld_case(VDF_MODE_YC, 4'h1, 1, 1'b1);
      fld_case(VDF_MODE_RAW, 4'h3, 3, 1'b0);
      fld_case(VDF_MODE_RAW, 4'h0, 16, 1'b0);
      wr(`VDF_OFS_CONTROL, {29'h0, VDF_MODE_BT656, 1'b1});
      wait_fid(1'b0, n1);
      wait_fid(1'b1, n1);
      rd(`VDF_OFS_IRQ_STATUS, 32'h7);
      wr(`VDF_OFS_IRQ_STATUS, 32'h7);
      wr(`VDF_OFS_IRQ_MASK, 32'h2);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      wait_fid(1'b0, n1);
      wait_fid(1'b1, n1);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h1);
      wr(`VDF_OFS_IRQ_STATUS, 32'h7);
      rd(`VDF_OFS_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`VDF_OFS_IRQ_MASK, 32'h0);
      wait_fid(1'b0, n1);
      wait_fid(1'b1, n1);
      @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      // Field 1 threshold 7, field 2 threshold 20, as for short lines.
      wr(`VDF_OFS_CONTROL, 32'h0);
      wr(`VDF_OFS_SPACE_THRESHOLD, 32'h0014_1007);
      wr(`VDF_OFS_FRAME_SIZE, 32'h00c8_0009);
      wr(`VDF_OFS_FIELD1_POSITION, 32'h0);
      wr(`VDF_OFS_FIELD2_POSITION, 32'h0064_0000);
      wr(`VDF_OFS_CONTROL, {29'h0, VDF_MODE_RAW, 1'b1});
      req_case(11'd6, 11'd4, 1'b0, 1'b0);
      req_case(11'd7, 11'd4, 1'b1, 1'b0);
      wr(`VDF_OFS_CONTROL, {29'h0, VDF_MODE_BT656, 1'b1});
      req_case(11'd6, 11'd3, 1'b0, 1'b0);
      req_case(11'd7, 11'd3, 1'b1, 1'b0);
      req_case(11'd6, 11'd4, 1'b0, 1'b1);
      lat <= 4'h6;
      wait_fid(1'b1, n1);
      req_case(11'd7, 11'd4, 1'b0, 1'b0);
      req_case(11'd20, 11'd9, 1'b1, 1'b0);
      req_case(11'd19, 11'd10, 1'b0, 1'b1);
      $display("dma test done");
      stop_test();
   end
endmodule // video_display_field_timing_threshold_test

`default_nettype wire
